// >>> core_exec_pkg.sv
package core_exec_pkg;
  // Opcode patterns, matched under the masks below
  localparam logic [7:0] OPC_ADD_WITH_CARRY_OP_REG = 8'h38;
  localparam logic [7:0] OPC_ADD_WITH_CARRY_OP_DIR = 8'h35;
  localparam logic [7:0] OPC_ADD_WITH_CARRY_OP_IND = 8'h36;
  localparam logic [7:0] OPC_ADD_WITH_CARRY_OP_IMM = 8'h34;
  localparam logic [7:0] OPC_AND_REG = 8'h58;
  localparam logic [7:0] OPC_AND_DIR = 8'h55;
  localparam logic [7:0] OPC_AND_IND = 8'h56;
  localparam logic [7:0] OPC_AND_IMM = 8'h54;
  localparam logic [7:0] OPC_AND_DIR_A = 8'h52;
  localparam logic [7:0] OPC_AND_DIR_IMM = 8'h53;
  localparam logic [7:0] OPC_ABSOLUTE_PAGE_JUMP = 8'h01;
  localparam logic [7:0] MASK_REG = 8'hF8;
  localparam logic [7:0] MASK_IND = 8'hFE;
  localparam logic [7:0] MASK_ABSOLUTE_PAGE_JUMP = 8'h1F;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  // Field positions and jump counter step
  localparam int ABSOLUTE_PAGE_JUMP_HI_LSB = 5;
  localparam int PAGE_LSB = 11;
  localparam int PC_STEP_ABSOLUTE_PAGE_JUMP = 2;
  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  // Operand source select
  localparam logic [1:0] SRC_REG = 2'h0;
  localparam logic [1:0] SRC_DIR = 2'h1;
  localparam logic [1:0] SRC_IND = 2'h2;
  localparam logic [1:0] SRC_IMM = 2'h3;
endpackage

// >>> add_with_carry_op_alu.sv
`timescale 1ns/10ps
module add_with_carry_op_alu
  import core_exec_pkg::*;
(
  input wire logic [7:0] acc_in,
  input wire logic [7:0] src_in,
  input wire logic carry_in,
  output logic [7:0] sum_out,
  output logic carry_bit_out,
  output logic half_carry_flag_out,
  output logic signed_overflow_flag_out
);
  logic [4:0] low_sum;
  logic [3:0] mid_sum;
  logic [1:0] top_sum;

  // Split adder exposes the carries out of bits 3, 6 and 7
  assign low_sum = {1'b0, acc_in[3:0]} + {1'b0, src_in[3:0]} + {4'h0, carry_in};
  assign mid_sum = {1'b0, acc_in[6:4]} + {1'b0, src_in[6:4]} + {3'h0, low_sum[4]};
  assign top_sum = {1'b0, acc_in[7]} + {1'b0, src_in[7]} + {1'b0, mid_sum[3]};
  assign sum_out = {top_sum[0], mid_sum[2:0], low_sum[3:0]};
  assign carry_bit_out = top_sum[1];
  assign half_carry_flag_out = low_sum[4];
  assign signed_overflow_flag_out = top_sum[1] ^ mid_sum[3];
endmodule

// >>> add_with_carry_op_absolute_page_jump_anl_execution.sv
`timescale 1ns/10ps
// What this block does
// - Add-with-carry sums source, carry and accumulator, result to accumulator.
// - Carry set on carry out of bit 7, half carry out of bit 3.
// - Overflow set when exactly one of carries out of bit 6, 7.
// - Add-with-carry takes register, direct, indirect, immediate sources; one cycle.
// - Absolute jump: counter plus two, then upper five bits, opcode 7-5, byte two.
// - Absolute jump stays in the 2K block of counter plus two; the load keeps those upper five bits.
// - Byte AND stores bitwise AND in destination; flags unchanged.
// - Byte AND has six operand combinations, accumulator or direct destination.
// - Byte AND with a port as destination reads the output latch, not the pins.
module add_with_carry_op_absolute_page_jump_anl_execution
  import core_exec_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic instr_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] byte2_in,
  input wire logic [7:0] byte3_in,
  input wire logic [7:0] working_register_in,
  input wire logic [7:0] direct_data_in,
  input wire logic [7:0] indirect_data_in,
  input wire logic [7:0] port_latch_in,
  input wire logic direct_is_port_in,
  input wire logic carry_bit_in,
  output logic [7:0] acc_out,
  output logic carry_bit_out,
  output logic half_carry_flag_out,
  output logic signed_overflow_flag_out,
  output logic [15:0] program_counter_out,
  output logic [2:0] working_register_sel_out,
  output logic pointer_register_sel_out,
  output logic [7:0] direct_addr_out,
  output logic [7:0] direct_wdata_out,
  output logic direct_we_out,
  output logic busy_out
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_JUMP = 2'b10
  } exec_state_e;

  function automatic logic op_match(input logic [7:0] op, input logic [7:0] pat,
                                    input logic [7:0] mask);
    op_match = (op & mask) == (pat & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  exec_state_e state_q, state_d;
  logic [7:0] acc_q;
  logic cy_q, ac_q, ov_q;
  logic [15:0] pc_q;
  logic [7:0] dwdata_q;
  logic dwe_q;
  logic [10:0] target_q;
  logic idle;
  wire take = instr_valid_in && idle;
  wire is_add_with_carry_op_reg = op_match(opcode_in, OPC_ADD_WITH_CARRY_OP_REG, MASK_REG);
  wire is_add_with_carry_op_dir = op_match(opcode_in, OPC_ADD_WITH_CARRY_OP_DIR, MASK_FULL);
  wire is_add_with_carry_op_ind = op_match(opcode_in, OPC_ADD_WITH_CARRY_OP_IND, MASK_IND);
  wire is_add_with_carry_op_imm = op_match(opcode_in, OPC_ADD_WITH_CARRY_OP_IMM, MASK_FULL);
  wire is_and_reg = op_match(opcode_in, OPC_AND_REG, MASK_REG);
  wire is_and_dir = op_match(opcode_in, OPC_AND_DIR, MASK_FULL);
  wire is_and_ind = op_match(opcode_in, OPC_AND_IND, MASK_IND);
  wire is_and_imm = op_match(opcode_in, OPC_AND_IMM, MASK_FULL);
  wire is_and_da = op_match(opcode_in, OPC_AND_DIR_A, MASK_FULL);
  wire is_and_di = op_match(opcode_in, OPC_AND_DIR_IMM, MASK_FULL);
  wire is_absolute_page_jump = op_match(opcode_in, OPC_ABSOLUTE_PAGE_JUMP, MASK_ABSOLUTE_PAGE_JUMP);
  wire add_with_carry_op = is_add_with_carry_op_reg | is_add_with_carry_op_dir | is_add_with_carry_op_ind | is_add_with_carry_op_imm;
  wire logical_and_acc = is_and_reg | is_and_dir | is_and_ind | is_and_imm;
  wire logical_and_mem = is_and_da | is_and_di;
  wire [1:0] src_sel = (is_add_with_carry_op_reg | is_and_reg) ? SRC_REG :
                       (is_add_with_carry_op_dir | is_and_dir) ? SRC_DIR :
                       (is_add_with_carry_op_ind | is_and_ind) ? SRC_IND : SRC_IMM;
  wire [7:0] src_byte = (src_sel == SRC_REG) ? working_register_in :
                        (src_sel == SRC_DIR) ? direct_data_in :
                        (src_sel == SRC_IND) ? indirect_data_in : byte2_in;
  // Ports read back the latch so pin loading cannot corrupt the masked bits
  wire [7:0] dest_orig = direct_is_port_in ? port_latch_in : direct_data_in;
  wire [7:0] and_mask = is_and_da ? acc_q : byte3_in;
  wire [7:0] and_acc_res = acc_q & src_byte;
  wire [7:0] and_mem_res = dest_orig & and_mask;
  // Instruction length in bytes for counter advance
  wire [15:0] ins_len = (is_add_with_carry_op_reg | is_add_with_carry_op_ind | is_and_reg | is_and_ind) ? 16'h0001 :
                        (is_and_di) ? 16'h0003 : 16'h0002;
  wire [15:0] pc_next = pc_q + ins_len;
  wire [15:0] pc_plus2 = pc_q + 16'(PC_STEP_ABSOLUTE_PAGE_JUMP);
  wire [10:0] in_page_target = {opcode_in[7:ABSOLUTE_PAGE_JUMP_HI_LSB], byte2_in};
  wire [7:0] sum;
  wire sum_cy, sum_ac, sum_ov;

  add_with_carry_op_alu u_alu (
    .acc_in(acc_q),
    .src_in(src_byte),
    .carry_in(carry_bit_in),
    .sum_out(sum),
    .carry_bit_out(sum_cy),
    .half_carry_flag_out(sum_ac),
    .signed_overflow_flag_out(sum_ov)
  );

  assign idle = (state_q == ST_IDLE);

  always_comb
  begin
    case (state_q)
      ST_IDLE: state_d = (take && is_absolute_page_jump) ? ST_JUMP : ST_IDLE;
      ST_JUMP: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Execute
  always_ff @(posedge core_clk_in)
  begin
    if (!resetn_in)
    begin
      state_q <= ST_IDLE;
      acc_q <= ACC_RESET;
      cy_q <= 1'b0;
      ac_q <= 1'b0;
      ov_q <= 1'b0;
      pc_q <= PC_RESET;
      dwdata_q <= 8'h00;
      dwe_q <= 1'b0;
      target_q <= 11'h000;
    end
    else
    begin
      state_q <= state_d;
      dwe_q <= 1'b0;
      if (take && add_with_carry_op)
      begin
        acc_q <= sum;
        cy_q <= sum_cy;
        ac_q <= sum_ac;
        ov_q <= sum_ov;
        pc_q <= pc_next;
      end
      else if (take && logical_and_acc)
      begin
        acc_q <= and_acc_res;
        pc_q <= pc_next;
      end
      else if (take && logical_and_mem)
      begin
        dwdata_q <= and_mem_res;
        dwe_q <= 1'b1;
        pc_q <= pc_next;
      end
      else if (take && is_absolute_page_jump)
      begin
        pc_q <= pc_plus2;
        target_q <= in_page_target;
      end
      else if (state_q == ST_JUMP)
      begin
        // Only the low eleven bits load, so no carry leaves the 2K block
        pc_q <= {pc_q[15:PAGE_LSB], target_q};
      end
    end
  end

  assign acc_out = acc_q;
  assign carry_bit_out = cy_q;
  assign half_carry_flag_out = ac_q;
  assign signed_overflow_flag_out = ov_q;
  assign program_counter_out = pc_q;
  assign working_register_sel_out = opcode_in[2:0];
  assign pointer_register_sel_out = opcode_in[0];
  assign direct_addr_out = byte2_in;
  assign direct_wdata_out = dwdata_q;
  assign direct_we_out = dwe_q;
  assign busy_out = !idle;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_add_with_carry_op_acc;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (take && add_with_carry_op) |=>
      (acc_q == $past(acc_q) + $past(src_byte) + 8'($past(carry_bit_in)));
  endproperty
  a_add_with_carry_op_acc: assert property (p_add_with_carry_op_acc) else $error("add_with_carry_op result wrong");

  property p_add_with_carry_op_cy;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (take && add_with_carry_op) |=>
      ({cy_q, acc_q} == 9'($past(acc_q)) + 9'($past(src_byte)) + 9'($past(carry_bit_in)));
  endproperty
  a_add_with_carry_op_cy: assert property (p_add_with_carry_op_cy) else $error("add_with_carry_op carry wrong");

  property p_add_with_carry_op_ac;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (take && add_with_carry_op) |=> ac_q == ((5'($past(acc_q[3:0])) + 5'($past(src_byte[3:0]))
      + 5'($past(carry_bit_in))) > 5'd15);
  endproperty
  a_add_with_carry_op_ac: assert property (p_add_with_carry_op_ac) else $error("half carry wrong");

  property p_add_with_carry_op_ov;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (take && add_with_carry_op) |=> ov_q == (($past(acc_q[7]) == $past(src_byte[7]))
      && (acc_q[7] != $past(acc_q[7])));
  endproperty
  a_add_with_carry_op_ov: assert property (p_add_with_carry_op_ov) else $error("overflow wrong");

  property p_add_with_carry_op_one_cycle;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (take && add_with_carry_op) |=> idle && (pc_q == $past(pc_q) + $past(ins_len));
  endproperty
  a_add_with_carry_op_one_cycle: assert property (p_add_with_carry_op_one_cycle) else $error("add_with_carry_op length wrong");

  sequence s_jump_step;
    take && is_absolute_page_jump ##1 (pc_q == $past(pc_plus2)) && busy_out;
  endsequence
  property p_absolute_page_jump;
    @(posedge core_clk_in) disable iff (!resetn_in)
    s_jump_step |=> idle && (pc_q[10:0] == $past(target_q)) && (pc_q[15:11] == $past(pc_q[15:11]));
  endproperty
  a_absolute_page_jump: assert property (p_absolute_page_jump) else $error("jump target wrong");

  property p_absolute_page_jump_page;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (state_q == ST_JUMP) |=> pc_q[15:11] == $past(pc_q[15:11]);
  endproperty
  a_absolute_page_jump_page: assert property (p_absolute_page_jump_page) else $error("jump left block");

  property p_and_flags;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (take && (logical_and_acc || logical_and_mem)) |=> $stable(cy_q) && $stable(ov_q) && $stable(ac_q);
  endproperty
  a_and_flags: assert property (p_and_flags) else $error("and touched flags");

  property p_and_port;
    @(posedge core_clk_in) disable iff (!resetn_in)
    (take && logical_and_mem && direct_is_port_in) |=>
      direct_we_out && (direct_wdata_out == ($past(port_latch_in) & $past(and_mask)));
  endproperty
  a_and_port: assert property (p_and_port) else $error("port latch not used");
endmodule

// >>> prog_mem_model.sv
`timescale 1ns/10ps
module prog_mem_model
(
  input wire logic [15:0] program_counter_in,
  output logic [7:0] opcode_out,
  output logic [7:0] byte2_out,
  output logic [7:0] byte3_out
);
  logic [7:0] mem [logic [15:0]];
  event load_ev;
  ////////////////////////////////////////////////////////////////////////////////
  // Unwritten bytes give a pattern that moves with the address, never a held value
  function automatic logic [7:0] rd(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : (a[7:0] ^ 8'hA5);
  endfunction
  task automatic load(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
    ->load_ev;
  endtask
  always @(program_counter_in or load_ev)
  begin
    opcode_out = rd(program_counter_in);
    byte2_out = rd(program_counter_in + 16'h0001);
    byte3_out = rd(program_counter_in + 16'h0002);
  end
endmodule

// >>> add_with_carry_op_absolute_page_jump_anl_execution_tb_top.sv
`timescale 1ns/10ps
module add_with_carry_op_absolute_page_jump_anl_execution_tb_top;
  import core_exec_pkg::*;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic [7:0] opcode_in, byte2_in, byte3_in, acc_out, direct_addr_out, direct_wdata_out;
  logic [7:0] working_register_in = 8'h00, direct_data_in = 8'h00;
  logic [7:0] indirect_data_in = 8'h00, port_latch_in = 8'h00;
  logic direct_is_port_in = 1'b0, carry_bit_in = 1'b0;
  logic carry_bit_out, half_carry_flag_out, signed_overflow_flag_out, pointer_register_sel_out;
  logic direct_we_out, busy_out;
  logic [15:0] program_counter_out;
  logic [2:0] working_register_sel_out;
  int num_errors = 0, compares = 0, seed = 86, cycles = 0;
  int acc_m, cy_m, ac_m, ov_m, pc_m, k;
  logic [7:0] tab [12] = '{OPC_ADD_WITH_CARRY_OP_REG, OPC_ADD_WITH_CARRY_OP_DIR, OPC_ADD_WITH_CARRY_OP_IND, OPC_ADD_WITH_CARRY_OP_IMM, OPC_AND_REG,
    OPC_AND_DIR, OPC_AND_IND, OPC_AND_IMM, OPC_AND_DIR_A, OPC_AND_DIR_IMM, OPC_ABSOLUTE_PAGE_JUMP, 8'hA5};
  logic [7:0] msk [12] = '{MASK_REG, MASK_FULL, MASK_IND, MASK_FULL, MASK_REG, MASK_FULL,
    MASK_IND, MASK_FULL, MASK_FULL, MASK_FULL, MASK_ABSOLUTE_PAGE_JUMP, MASK_FULL};
  logic [7:0] rnd;
  always #12.5 core_clk_in = ~core_clk_in;
  add_with_carry_op_absolute_page_jump_anl_execution u_add_with_carry_op_absolute_page_jump_anl_execution (.*);
  prog_mem_model u_prog_mem_model (.program_counter_in(program_counter_out),
    .opcode_out(opcode_in), .byte2_out(byte2_in), .byte3_out(byte3_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_state();
    chk({8'h00, acc_out}, 16'(acc_m));
    chk({15'h0, carry_bit_out}, 16'(cy_m));
    chk({15'h0, half_carry_flag_out}, 16'(ac_m));
    chk({15'h0, signed_overflow_flag_out}, 16'(ov_m));
    chk(program_counter_out, 16'(pc_m));
  endtask
  task automatic do_reset(input int n);
    instr_valid_in = 1'b0;
    resetn_in = 1'b0;
    repeat (n) @(posedge core_clk_in);
    #2 resetn_in = 1'b1;
    {acc_m, cy_m, ac_m, ov_m, pc_m} = '0;
    check_state();
    chk({15'h0, direct_we_out}, 16'h0000);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Inputs stay put until the next step; expectations sample them before the edge
  task automatic step(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
    int src, cin, orig, len, s, wd;
    u_prog_mem_model.load(16'(pc_m), op);
    u_prog_mem_model.load(16'(pc_m + 1), b2);
    u_prog_mem_model.load(16'(pc_m + 2), b3);
    {working_register_in, direct_data_in, indirect_data_in, port_latch_in} = $random(seed);
    {direct_is_port_in, carry_bit_in} = 2'($random(seed));
    instr_valid_in = 1'b1;
    #1;
    chk({13'h0, working_register_sel_out}, {13'h0, op[2:0]});
    chk({15'h0, pointer_register_sel_out}, {15'h0, op[0]});
    chk({8'h00, direct_addr_out}, {8'h00, b2});
    src = op[3] ? working_register_in : op[1] ? indirect_data_in : op[0] ? direct_data_in : b2;
    cin = carry_bit_in;
    len = (op[3] | op[1]) ? 1 : 2;
    orig = direct_is_port_in ? port_latch_in : direct_data_in;
    wd = -1;
    @(posedge core_clk_in);
    #2;
    if (op[7:4] == 4'h3 && op[3:2] != 2'b00)
    begin
      s = acc_m + src + cin;
      ac_m = ((acc_m & 15) + (src & 15) + cin) >> 4;
      ov_m = (((acc_m & 127) + (src & 127) + cin) >> 7) ^ (s >> 8);
      cy_m = s >> 8;
      acc_m = s & 255;
      pc_m += len;
    end
    else if (op[7:4] == 4'h5 && op[3:2] != 2'b00)
    begin
      acc_m = acc_m & src;
      pc_m += len;
    end
    else if (op == OPC_AND_DIR_A || op == OPC_AND_DIR_IMM)
    begin
      wd = orig & (op[0] ? b3 : acc_m);
      pc_m += op[0] ? 3 : 2;
    end
    else if (op[4:0] == 5'h01)
    begin
      pc_m = (pc_m + 2) & 65535;
      chk(program_counter_out, 16'(pc_m));
      chk({15'h0, busy_out}, 16'h0001);
      // Valid stays high through the busy cycle and must be ignored
      @(posedge core_clk_in);
      #2;
      pc_m = (pc_m & 16'hF800) | (op[7:5] << 8) | b2;
    end
    pc_m &= 65535;
    chk({15'h0, direct_we_out}, {15'h0, wd >= 0});
    if (wd >= 0)
      chk({8'h00, direct_wdata_out}, 16'(wd));
    chk({15'h0, busy_out}, 16'h0000);
    check_state();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  initial
  begin
    do_reset(5);
    step(8'h61, 8'hFE, 8'h00);
    // Lands on the last two bytes of a block, so the next jump's page comes from the next block
    step(8'hE1, 8'hFE, 8'h00);
    step(8'h21, 8'h34, 8'h00);
    for (int i = 0; i < 600; i++)
    begin
      k = (i < 12) ? i : int'($unsigned($random(seed)) % 12);
      rnd = 8'($random(seed));
      step(tab[k] | (rnd & ~msk[k]), 8'($random(seed)), 8'($random(seed)));
      if (i == 300)
        do_reset(2);
    end
    wrap_up();
  end
endmodule
